// File: idsl_chk.sv
`timescale 1ns/100ps
module idsl_chk (
   input wire clk_i,
   input wire rst_i,
   input wire upstream_network_port_link_i,
   input wire downstream_network_port_link_i,
   input wire [2:0] app_state_i,
   input wire sensor_supply_overload_i,
   input wire actuator_supply_ok_i,
   input wire [15:0] chan_state_i,
   input wire [15:0] chan_fault_i,
   input wire link_lamp_green_o,
   input wire ready_lamp_green_o,
   input wire ready_lamp_yellow_o,
   input wire ready_lamp_red_o,
   input wire run_lamp_green_o,
   input wire sensor_supply_lamp_green_o,
   input wire sensor_supply_lamp_red_o,
   input wire actuator_supply_lamp_green_o,
   input wire [15:0] chan_lamp_yellow_o,
   input wire [15:0] chan_lamp_red_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_LINK_ON: assert property (
      (upstream_network_port_link_i || downstream_network_port_link_i) |=> link_lamp_green_o)
      else $error("link lamp dark while a port is linked");
   AST_LINK_OFF: assert property (
      !(upstream_network_port_link_i || downstream_network_port_link_i) |=> !link_lamp_green_o)
      else $error("link lamp lit with no port linked");
   AST_RUN_OP: assert property (
      app_state_i == 3'h5 ##1 app_state_i == 3'h5 |=> run_lamp_green_o)
      else $error("run lamp dark in operational state");
   AST_SUP_OVL: assert property (
      sensor_supply_overload_i |=> sensor_supply_lamp_red_o && !sensor_supply_lamp_green_o)
      else $error("sensor lamp not red on overload");
   AST_ACT_ON: assert property (
      actuator_supply_ok_i |=> actuator_supply_lamp_green_o)
      else $error("actuator lamp dark with supply present");
   AST_CHAN: assert property (
      chan_fault_i == 16'h0 |=> chan_lamp_yellow_o == $past(chan_state_i) && chan_lamp_red_o == 16'h0)
      else $error("channel lamps do not follow channel state");
   AST_RED_HOLD: assert property (
      ready_lamp_red_o |=> ready_lamp_red_o)
      else $error("ready red dropped without a restart");
   AST_RDY_ONE: assert property (
      $onehot0({ready_lamp_green_o, ready_lamp_yellow_o, ready_lamp_red_o}))
      else $error("ready lamp shows two colours at once");
endmodule // idsl_chk
////////////////////////////////////////////////////////////////////////////////
bind idsl_top idsl_chk idsl_chk_i (.*);

// File: idsl_defs.vh
`ifndef IDSL_DEFS_VH
`define IDSL_DEFS_VH
// Register offsets (byte addresses, one word each)
`define IDSL_ADR_CTRL 4'h0
`define IDSL_ADR_STAT 4'h4
`define IDSL_ADR_IDV 4'h8
`define IDSL_ADR_CHDIR 4'hc
// Control register fields
`define IDSL_CTRL_START 0
`define IDSL_CTRL_FWUPD 1
`define IDSL_CTRL_CRIT 2
`define IDSL_CTRL_CFGERR 3
`define IDSL_CTRL_APPERR 4
`define IDSL_CTRL_WDOG 5
`define IDSL_CTRL_RESET 32'h0000_0000
// Identification value reset (arbitrary neutral value)
`define IDSL_IDV_RESET 8'h00
`define IDSL_CODE_MIN 8'h01
`define IDSL_CODE_MAX 8'h9f
`define IDSL_TENS_MAX 4'hf
`define IDSL_UNITS_MAX 4'h9
// Application states
`define IDSL_ST_INIT 3'h1
`define IDSL_ST_PREOP 3'h2
`define IDSL_ST_BOOT 3'h3
`define IDSL_ST_SAFEOP 3'h4
`define IDSL_ST_OP 3'h5
// Timing
`define IDSL_CLK_HZ 10000000
`define IDSL_SLOW_HZ 5
`define IDSL_FAST_HZ 20
`define IDSL_FLASH_ON_MS 200
`define IDSL_FLASH_OFF_MS 1000
`define IDSL_PULSE_MS 200
`define IDSL_SLOW_HALF (`IDSL_CLK_HZ / `IDSL_SLOW_HZ)
`define IDSL_FAST_HALF (`IDSL_CLK_HZ / `IDSL_FAST_HZ)
`define IDSL_ON_CYC (`IDSL_CLK_HZ / 1000 * `IDSL_FLASH_ON_MS)
`define IDSL_OFF_CYC (`IDSL_CLK_HZ / 1000 * `IDSL_FLASH_OFF_MS)
`endif

// File: idsl_partner.sv
`timescale 1ns/100ps
module idsl_partner (
   input wire clk_i,
   output logic [3:0] tens_digit_switch_o = 4'h7,
   output logic [3:0] units_digit_switch_o = 4'h7,
   output logic up_link_o = 1'b0,
   output logic dn_link_o = 1'b0
);
   // Station address from the master, apart from the switch value
   logic [15:0] station_addr_q = 16'h0001;
   task set_sw(input logic [3:0] t, input logic [3:0] u);
      @(posedge clk_i);
      tens_digit_switch_o <= t;
      units_digit_switch_o <= u;
   endtask
   task set_link(input logic u, input logic d);
      @(posedge clk_i);
      up_link_o <= u;
      dn_link_o <= d;
   endtask
endmodule // idsl_partner

// File: idsl_top.v
// How it works
// - Rotary switch sampled only at startup
// - Code is tens times ten plus units
// - Valid code 01..159 becomes identification value
// - Invalid position keeps previous identification
// - Ready lamp steady red on invalid switch
// - Startup refuses connections until the start bit is set, whatever the ready lamp shows
// - Link lamp green when either port linked
// - Ready lamp flashes yellow during firmware update
// - Ready lamp alternates on supply/temperature fault
// - Ready lamp off when not ready, unless the switch is invalid or firmware update is set
// - Run lamp: off, 2.5 Hz, steady by state
// - Safe-operational: 200 ms on, 1000 ms off
// - Bootstrap state: run lamp flashes 10 Hz
// - Error lamp red on critical error, off when no error bit is set
// - Error lamp 2.5 Hz on configuration error
// - Single pulse application, double pulse watchdog
// - Sensor lamp green present, red overload
// - Actuator lamp green when voltage present
// - Channel lamp yellow set, red output fault
// - Channel lamps numbered byte then bit
`timescale 1ns/100ps
`include "idsl_defs.vh"
module idsl_top
#(
   parameter SLOW_HALF = `IDSL_SLOW_HALF,
   parameter FAST_HALF = `IDSL_FAST_HALF,
   parameter ON_CYC = `IDSL_ON_CYC,
   parameter OFF_CYC = `IDSL_OFF_CYC
)
(
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [3:0] tens_digit_switch_i,
   input wire [3:0] units_digit_switch_i,
   input wire upstream_network_port_link_i,
   input wire downstream_network_port_link_i,
   input wire [2:0] app_state_i,
   input wire sensor_supply_ok_i,
   input wire sensor_supply_volt_fault_i,
   input wire sensor_supply_overload_i,
   input wire temp_critical_i,
   input wire actuator_supply_ok_i,
   input wire [15:0] chan_state_i,
   input wire [15:0] chan_fault_i,
   output reg conn_enable_o,
   output reg link_lamp_green_o,
   output reg ready_lamp_green_o,
   output reg ready_lamp_yellow_o,
   output reg ready_lamp_red_o,
   output reg run_lamp_green_o,
   output reg err_lamp_red_o,
   output reg sensor_supply_lamp_green_o,
   output reg sensor_supply_lamp_red_o,
   output reg actuator_supply_lamp_green_o,
   output reg [15:0] chan_lamp_yellow_o,
   output reg [15:0] chan_lamp_red_o
);

////////////////////////////////////////////////////////////////////////////////
// Switch decoding

function [7:0] code_of;
   input [3:0] tens;
   input [3:0] units;
   begin
      code_of = {4'h0, tens} * 8'h0a + {4'h0, units};
   end
endfunction

function code_ok;
   input [3:0] tens;
   input [3:0] units;
   reg [7:0] c;
   begin
      c = code_of(tens, units);
      code_ok = (tens <= `IDSL_TENS_MAX) && (units <= `IDSL_UNITS_MAX) &&
                (c >= `IDSL_CODE_MIN) && (c <= `IDSL_CODE_MAX);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [5:0] ctrl_q;
reg [15:0] chdir_q;
reg [7:0] idv_q;
reg sw_bad_q;
reg sampled_q;
reg ready_q;
reg [23:0] slow_cnt_q;
reg slow_ph_q;
reg [23:0] fast_cnt_q;
reg fast_ph_q;
reg [23:0] sf_cnt_q;
reg sf_on_q;
reg [23:0] pul_cnt_q;
reg [2:0] pul_ph_q;

wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire started = ctrl_q[`IDSL_CTRL_START];

// Identification sampled once after each reset, kept across reset if invalid
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      sampled_q <= 1'b0;
      sw_bad_q <= 1'b0;
   end
   else if (!sampled_q)
   begin
      sampled_q <= 1'b1;
      if (code_ok(tens_digit_switch_i, units_digit_switch_i))
      begin
         idv_q <= code_of(tens_digit_switch_i, units_digit_switch_i);
         sw_bad_q <= 1'b0;
      end
      else
      begin
         sw_bad_q <= 1'b1;
      end
   end
end

// Identification register is not reset so it survives a restart
initial idv_q = `IDSL_IDV_RESET;

// Bus slave
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ctrl_q <= 6'h00;
      chdir_q <= 16'h0000;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
   end
   else
   begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i)
      begin
         if (wb_adr_i == `IDSL_ADR_CTRL && wb_sel_i[0])
            ctrl_q <= wb_dat_i[5:0];
         if (wb_adr_i == `IDSL_ADR_CHDIR)
         begin
            if (wb_sel_i[0])
               chdir_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               chdir_q[15:8] <= wb_dat_i[15:8];
         end
      end
      if (wb_req && !wb_we_i)
      begin
         case (wb_adr_i)
            `IDSL_ADR_CTRL: wb_dat_o <= {26'h0, ctrl_q};
            `IDSL_ADR_STAT: wb_dat_o <= {28'h0, ready_q, sw_bad_q, sampled_q,
                                         link_lamp_green_o};
            `IDSL_ADR_IDV: wb_dat_o <= {24'h0, idv_q};
            `IDSL_ADR_CHDIR: wb_dat_o <= {16'h0, chdir_q};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Blink generators

// Slow cadence: phase toggles every SLOW_HALF cycles
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      slow_cnt_q <= 24'h0;
      slow_ph_q <= 1'b0;
   end
   else if (slow_cnt_q == SLOW_HALF[23:0] - 24'h1)
   begin
      slow_cnt_q <= 24'h0;
      slow_ph_q <= !slow_ph_q;
   end
   else
   begin
      slow_cnt_q <= slow_cnt_q + 24'h1;
   end
end

// Fast cadence: phase toggles every FAST_HALF cycles
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      fast_cnt_q <= 24'h0;
      fast_ph_q <= 1'b0;
   end
   else if (fast_cnt_q == FAST_HALF[23:0] - 24'h1)
   begin
      fast_cnt_q <= 24'h0;
      fast_ph_q <= !fast_ph_q;
   end
   else
   begin
      fast_cnt_q <= fast_cnt_q + 24'h1;
   end
end

// Single flash: ON_CYC lit, then OFF_CYC dark
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      sf_cnt_q <= 24'h0;
      sf_on_q <= 1'b1;
   end
   else if (sf_on_q ? (sf_cnt_q == ON_CYC[23:0] - 24'h1)
                    : (sf_cnt_q == OFF_CYC[23:0] - 24'h1))
   begin
      sf_cnt_q <= 24'h0;
      sf_on_q <= !sf_on_q;
   end
   else
   begin
      sf_cnt_q <= sf_cnt_q + 24'h1;
   end
end

// Pulse frame: eight slots of ON_CYC, pulses sit in slots 0 and 2
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      pul_cnt_q <= 24'h0;
      pul_ph_q <= 3'h0;
   end
   else if (pul_cnt_q == ON_CYC[23:0] - 24'h1)
   begin
      pul_cnt_q <= 24'h0;
      pul_ph_q <= pul_ph_q + 3'h1;
   end
   else
   begin
      pul_cnt_q <= pul_cnt_q + 24'h1;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Lamp next values

wire supply_fault = sensor_supply_volt_fault_i || temp_critical_i ||
                    sensor_supply_overload_i;
wire [15:0] chan_short = chdir_q & chan_fault_i;

reg ready_d;
reg conn_enable_d;
reg link_lamp_green_d;
reg ready_lamp_green_d;
reg ready_lamp_yellow_d;
reg ready_lamp_red_d;
reg run_lamp_green_d;
reg err_lamp_red_d;
reg sensor_supply_lamp_green_d;
reg sensor_supply_lamp_red_d;
reg actuator_supply_lamp_green_d;
reg [15:0] chan_lamp_yellow_d;
reg [15:0] chan_lamp_red_d;

// Ready lamp: one colour at a time, by fixed priority
always @*
begin
   ready_lamp_green_d = 1'b0;
   ready_lamp_yellow_d = 1'b0;
   ready_lamp_red_d = 1'b0;
   if (sampled_q && sw_bad_q)
   begin
      ready_lamp_red_d = 1'b1;
   end
   else if (ctrl_q[`IDSL_CTRL_FWUPD])
   begin
      ready_lamp_yellow_d = slow_ph_q;
   end
   else if (ready_q && supply_fault)
   begin
      ready_lamp_green_d = slow_ph_q;
      ready_lamp_yellow_d = !slow_ph_q;
   end
   else if (ready_q)
   begin
      ready_lamp_green_d = 1'b1;
   end
end

// Run lamp follows the slave state
always @*
begin
   case (app_state_i)
      `IDSL_ST_PREOP: run_lamp_green_d = slow_ph_q;
      `IDSL_ST_SAFEOP: run_lamp_green_d = sf_on_q;
      `IDSL_ST_OP: run_lamp_green_d = 1'b1;
      `IDSL_ST_BOOT: run_lamp_green_d = fast_ph_q;
      default: run_lamp_green_d = 1'b0;
   endcase
end

// Error lamp: critical, then configuration, then watchdog, then application
always @*
begin
   if (ctrl_q[`IDSL_CTRL_CRIT])
   begin
      err_lamp_red_d = 1'b1;
   end
   else if (ctrl_q[`IDSL_CTRL_CFGERR])
   begin
      err_lamp_red_d = slow_ph_q;
   end
   else if (ctrl_q[`IDSL_CTRL_WDOG])
   begin
      err_lamp_red_d = (pul_ph_q == 3'h0) || (pul_ph_q == 3'h2);
   end
   else if (ctrl_q[`IDSL_CTRL_APPERR])
   begin
      err_lamp_red_d = (pul_ph_q == 3'h0);
   end
   else
   begin
      err_lamp_red_d = 1'b0;
   end
end

// Start, link, supply and channel lamps
always @*
begin
   ready_d = started && sampled_q;
   conn_enable_d = ready_q;
   link_lamp_green_d = upstream_network_port_link_i ||
                       downstream_network_port_link_i;
   sensor_supply_lamp_red_d = sensor_supply_overload_i;
   sensor_supply_lamp_green_d = sensor_supply_ok_i && !sensor_supply_overload_i;
   actuator_supply_lamp_green_d = actuator_supply_ok_i;
   chan_lamp_red_d = chan_short;
   chan_lamp_yellow_d = chan_state_i & ~chan_short;
end

// Output and status flip-flops
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ready_q <= 1'b0;
      conn_enable_o <= 1'b0;
      link_lamp_green_o <= 1'b0;
      ready_lamp_green_o <= 1'b0;
      ready_lamp_yellow_o <= 1'b0;
      ready_lamp_red_o <= 1'b0;
      run_lamp_green_o <= 1'b0;
      err_lamp_red_o <= 1'b0;
      sensor_supply_lamp_green_o <= 1'b0;
      sensor_supply_lamp_red_o <= 1'b0;
      actuator_supply_lamp_green_o <= 1'b0;
      chan_lamp_yellow_o <= 16'h0000;
      chan_lamp_red_o <= 16'h0000;
   end
   else
   begin
      ready_q <= ready_d;
      conn_enable_o <= conn_enable_d;
      link_lamp_green_o <= link_lamp_green_d;
      ready_lamp_green_o <= ready_lamp_green_d;
      ready_lamp_yellow_o <= ready_lamp_yellow_d;
      ready_lamp_red_o <= ready_lamp_red_d;
      run_lamp_green_o <= run_lamp_green_d;
      err_lamp_red_o <= err_lamp_red_d;
      sensor_supply_lamp_green_o <= sensor_supply_lamp_green_d;
      sensor_supply_lamp_red_o <= sensor_supply_lamp_red_d;
      actuator_supply_lamp_green_o <= actuator_supply_lamp_green_d;
      chan_lamp_yellow_o <= chan_lamp_yellow_d;
      chan_lamp_red_o <= chan_lamp_red_d;
   end
end

endmodule // idsl_top

// File: test_idsl_top.sv
`timescale 1ns/100ps
module test_idsl_top;
   localparam SH = 4, FH = 2, ON = 4, OFF = 20, W = 96;
   logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, rd;
   logic [2:0] app_state_i = 3'h1;
   logic sensor_supply_ok_i = 1, sensor_supply_volt_fault_i = 0, sensor_supply_overload_i = 0;
   logic temp_critical_i = 0, actuator_supply_ok_i = 0;
   logic [15:0] chan_state_i = 16'h0, chan_fault_i = 16'h0;
   wire [31:0] wb_dat_o;
   wire [3:0] tens_digit_switch_i, units_digit_switch_i;
   wire [15:0] chan_lamp_yellow_o, chan_lamp_red_o;
   wire wb_ack_o, upstream_network_port_link_i, downstream_network_port_link_i, conn_enable_o;
   wire link_lamp_green_o, ready_lamp_green_o, ready_lamp_yellow_o, ready_lamp_red_o;
   wire run_lamp_green_o, err_lamp_red_o, sensor_supply_lamp_green_o, sensor_supply_lamp_red_o;
   wire actuator_supply_lamp_green_o;
   int fails = 0, checks = 0, n, m;
   always #50 clk_i = ~clk_i;
   idsl_top #(.SLOW_HALF(SH), .FAST_HALF(FH), .ON_CYC(ON), .OFF_CYC(OFF)) idsl_top_i (.*);
   idsl_partner idsl_partner_i (.clk_i(clk_i), .tens_digit_switch_o(tens_digit_switch_i),
      .units_digit_switch_o(units_digit_switch_i), .up_link_o(upstream_network_port_link_i),
      .dn_link_o(downstream_network_port_link_i));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   task boot(input logic [3:0] t, input logic [3:0] u);
      idsl_partner_i.set_sw(t, u);
      rst_i <= 1;
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      repeat (4) @(posedge clk_i);
   endtask
   // Lit cycles of one lamp over a window of whole blink periods
   task cnt(input int s, output int c);
      c = 0;
      repeat (W)
      begin
         @(posedge clk_i);
         #1;
         c += (s == 0) ? run_lamp_green_o : (s == 1) ? err_lamp_red_o :
            (s == 2) ? ready_lamp_yellow_o : ready_lamp_green_o;
      end
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_switch;
      logic [3:0] t [5] = '{4'h7, 4'h0, 4'hf, 4'h2, 4'h1};
      logic [3:0] u [5] = '{4'h7, 4'h0, 4'h9, 4'ha, 4'h6};
      logic [7:0] e [5] = '{8'h4d, 8'h4d, 8'h9f, 8'h9f, 8'h10};
      for (int i = 0; i < 5; i++)
      begin
         boot(t[i], u[i]);
         wb(0, 4'h8, 0);
         chk("idv", rd, {24'h0, e[i]});
         chk("ready red", ready_lamp_red_o, i == 1 || i == 3);
      end
      idsl_partner_i.set_sw(4'h3, 4'h3);
      wb(1, 4'h8, 32'hff);
      wb(0, 4'h8, 0);
      chk("idv held", rd, 32'h10);
      wb(0, 4'h2, 0);
      chk("unmapped", rd, 32'h0);
   endtask
   task t_ready;
      chk("idle", {conn_enable_o, ready_lamp_green_o}, 2'b00);
      wb(1, 4'h0, 32'h1);
      repeat (4) @(posedge clk_i);
      chk("ready", {conn_enable_o, ready_lamp_green_o}, 2'b11);
      wb(1, 4'h0, 32'h3);
      cnt(2, n);
      chk("update blink", n, W / 2);
      sensor_supply_volt_fault_i <= 1;
      cnt(3, n);
      chk("update first", n, 0);
      wb(1, 4'h0, 32'h1);
      for (int k = 0; k < 3; k++)
      begin
         sensor_supply_volt_fault_i <= k == 0;
         temp_critical_i <= k == 1;
         sensor_supply_overload_i <= k == 2;
         cnt(3, n);
         cnt(2, m);
         chk("fault green", n, W / 2);
         chk("fault yellow", m, W / 2);
      end
      chk("overload sensor red", sensor_supply_lamp_red_o, 1);
      sensor_supply_overload_i <= 0;
   endtask
   task t_run;
      logic [2:0] s [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
      int e [5] = '{0, W / 2, W / 2, W * ON / (ON + OFF), W};
      for (int i = 0; i < 5; i++)
      begin
         app_state_i <= s[i];
         repeat (4) @(posedge clk_i);
         cnt(0, n);
         chk("run lit", n, e[i]);
      end
   endtask
   task t_err;
      logic [31:0] c [5] = '{32'h5, 32'h9, 32'h11, 32'h21, 32'h1};
      int e [5] = '{W, W / 2, W / 8, W / 4, 0};
      for (int i = 0; i < 5; i++)
      begin
         wb(1, 4'h0, c[i]);
         repeat (4) @(posedge clk_i);
         cnt(1, n);
         chk("err lit", n, e[i]);
      end
   endtask
   task t_io;
      chk("actuator off", actuator_supply_lamp_green_o, 0);
      chk("sensor green", {sensor_supply_lamp_red_o, sensor_supply_lamp_green_o}, 2'b01);
      for (int i = 0; i < 4; i++)
      begin
         idsl_partner_i.set_link(i[0], i[1]);
         repeat (2) @(posedge clk_i);
         chk("link", link_lamp_green_o, i != 0);
      end
      actuator_supply_ok_i <= 1;
      sensor_supply_overload_i <= 1;
      chan_state_i <= 16'h8001;
      chan_fault_i <= 16'h8001;
      wb(1, 4'hc, 32'h8000);
      repeat (3) @(posedge clk_i);
      chk("actuator", actuator_supply_lamp_green_o, 1);
      chk("sensor", {sensor_supply_lamp_red_o, sensor_supply_lamp_green_o}, 2'b10);
      chk("chan red", chan_lamp_red_o, 16'h8000);
      chan_fault_i <= 16'h0;
      sensor_supply_ok_i <= 0;
      sensor_supply_overload_i <= 0;
      repeat (2) @(posedge clk_i);
      chk("chan yellow", chan_lamp_yellow_o, 16'h8001);
      chk("sensor absent", {sensor_supply_lamp_red_o, sensor_supply_lamp_green_o}, 2'b00);
      wb(0, 4'hc, 0);
      chk("chdir", rd, 32'h8000);
      wb(0, 4'h4, 0);
      chk("status", rd, 32'hb);
      wb(0, 4'h0, 0);
      chk("ctrl", rd, 32'h1);
   endtask
   initial
   begin
      #(100 * 20000);
      fails++;
      final_report;
   end
   initial
   begin
      t_switch;
      t_ready;
      t_run;
      t_err;
      t_io;
      final_report;
   end
endmodule // test_idsl_top
